// ===== common/fpg_map.svh
/*
 Offsets, field positions, reset values and codes of the flash page guard.
 Assumes a 32-bit register port with byte offsets and 15-bit flash byte addresses.
*/
`ifndef FPG_MAP_SVH
`define FPG_MAP_SVH

`define FPG_OFS_CTRL 8'h00
`define FPG_OFS_LOCK 8'h08
`define FPG_OFS_ENA 8'h20
`define FPG_OFS_FLAG 8'h24
`define FPG_OFS_CLR 8'h28

`define FPG_KEY 16'h5a5a
`define FPG_GROUPS 10
`define FPG_LOCK_RST 10'h000
`define FPG_STANDBY_RST 1'b1
`define FPG_CFG_MAX 6'h30

`define FPG_EV_PC 0
`define FPG_EV_LOCK 1
`define FPG_EV_PROG 4
`define FPG_EV_MASK 5'h13

`define FPG_MODE_READ 2'h0
`define FPG_MODE_PROG 2'h1
`define FPG_MODE_PAGE 2'h2
`define FPG_MODE_CHIP 2'h3

`define FPG_LVL_0 2'h0
`define FPG_LVL_1 2'h1
`define FPG_LVL_2 2'h2
`define FPG_LVL_3 2'h3

`define FPG_SIZE_8 2'h0
`define FPG_SIZE_16 2'h1
`define FPG_SIZE_32 2'h2

`endif

// ===== common/fpg_pkg.sv
/*
 Types and shared decoding of the flash page guard.
 Assumes fpg_map.svh is on the include path.
*/
`include "fpg_map.svh"
package fpg_pkg;
    typedef enum logic [1:0] {src_cpu, src_debug, src_boot} fpg_src_e;
    typedef enum logic [1:0] {st_idle, st_op, st_wipe} fpg_state_e;

    // width-aligned test on the low address bits
    function automatic logic fpg_aligned(input logic [1:0] size, input logic [1:0] low);
        logic ok;
        ok = 1'b0;
        case (size)
            `FPG_SIZE_8: ok = 1'b1;
            `FPG_SIZE_16: ok = (low[0] == 1'b0);
            `FPG_SIZE_32: ok = (low == 2'h0);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : fpg_aligned
endpackage : fpg_pkg

// ===== hdl/fpg_guard.sv
/*
 Flash page guard: group locks, executing-page guard, event flags, protection
 level, fetch stall and low-power hand-off, with a plain register port.
 Assumes the flash array macro starts on op_go and pulses array_done when finished.
*/
// Added by the designer: the plain strobed port and the register offsets.
`include "fpg_map.svh"
module fpg_guard (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // erase or write request from the system bus
    input wire logic op_req,
    input wire logic [14:0] op_addr,
    input wire logic [1:0] op_size,
    // cpu execution state
    input wire logic exec_in_flash,
    input wire logic [14:0] pc_addr,
    output logic fetch_stall,
    // flash array macro
    output logic op_go,
    output logic [1:0] op_kind,
    output logic [5:0] op_page,
    input wire logic array_done,
    input wire logic array_prog_err,
    // read path
    input wire logic rd_req,
    input wire fpg_pkg::fpg_src_e rd_src,
    input wire logic [1:0] rd_size,
    input wire logic [1:0] rd_low,
    input wire logic [31:0] rd_word,
    output logic [31:0] rd_data,
    output logic rd_valid,
    output logic rd_denied,
    // protection level change
    input wire logic lvl_req,
    input wire logic [1:0] lvl_value,
    input wire fpg_pkg::fpg_src_e lvl_src,
    output logic lvl_done,
    output logic lvl_refused,
    // system state and alarms
    input wire logic lowest_power_state,
    output logic flash_lowpower,
    output logic severe_fault_exception,
    output logic irq
);
    typedef struct packed {
        fpg_pkg::fpg_state_e state;
        logic [9:0] lock;
        logic [1:0] mode;
        logic standby;
        logic [4:0] enables;
        logic [4:0] flags;
        logic [1:0] level;
        logic [5:0] cfg_count;
        logic stall;
        logic [31:0] rdata;
        logic go;
        logic [1:0] kind;
        logic [5:0] page;
        logic op_fault;
        logic done;
        logic refused;
        logic lowpower;
    } fpg_guard_s;

    fpg_guard_s q;
    fpg_guard_s next_q;

    logic key_ok;
    logic [5:0] tgt_page;
    logic [3:0] tgt_group;
    logic group_open;
    logic on_pc_page;
    logic op_aligned;
    logic erase_or_write;
    logic lower_ok;
    logic raise_ok;
    logic rd_fault;
    logic [4:0] set_ev;
    logic [4:0] clr_ev;

    always_comb begin
        next_q = q;
        next_q.go = 1'b0;
        next_q.done = 1'b0;
        next_q.refused = 1'b0;
        next_q.op_fault = 1'b0;
        next_q.rdata = 32'h0;
        set_ev = 5'h0;
        clr_ev = 5'h0;

        key_ok = (reg_wdata[31:16] == `FPG_KEY);
        tgt_page = op_addr[14:9];
        tgt_group = op_addr[14:11];
        group_open = (tgt_group < 4'(`FPG_GROUPS)) && q.lock[tgt_group];
        on_pc_page = exec_in_flash && (pc_addr[14:9] == tgt_page);
        op_aligned = fpg_pkg::fpg_aligned(op_size, op_addr[1:0]);
        erase_or_write = (q.mode != `FPG_MODE_READ);
        lower_ok = 1'b0;
        case (q.level)
            `FPG_LVL_1: lower_ok = (lvl_src != fpg_pkg::src_cpu);
            `FPG_LVL_2: lower_ok = (lvl_src == fpg_pkg::src_boot);
            default: lower_ok = 1'b0;
        endcase
        lower_ok = lower_ok && (lvl_value == `FPG_LVL_0);
        raise_ok = (lvl_src == fpg_pkg::src_boot) && (lvl_value > q.level);

        // register writes
        if (reg_write) begin
            case (reg_addr)
                `FPG_OFS_CTRL: begin
                    if (key_ok) begin
                        next_q.mode = reg_wdata[1:0];
                        next_q.standby = reg_wdata[4];
                    end
                end
                `FPG_OFS_LOCK: begin
                    if (key_ok) begin
                        next_q.lock = reg_wdata[9:0];
                    end
                end
                `FPG_OFS_ENA: next_q.enables = reg_wdata[4:0] & `FPG_EV_MASK;
                `FPG_OFS_CLR: clr_ev = ~reg_wdata[4:0] & `FPG_EV_MASK;
                default: clr_ev = 5'h0;
            endcase
        end

        // register reads, answered one cycle later
        if (reg_read) begin
            case (reg_addr)
                `FPG_OFS_CTRL: next_q.rdata = {24'h0, q.level, q.state != fpg_pkg::st_idle,
                    q.standby, 2'h0, q.mode};
                `FPG_OFS_LOCK: next_q.rdata = {22'h0, q.lock};
                `FPG_OFS_ENA: next_q.rdata = {27'h0, q.enables};
                `FPG_OFS_FLAG: next_q.rdata = {27'h0, q.flags};
                default: next_q.rdata = 32'h0;
            endcase
        end

        case (q.state)
            fpg_pkg::st_idle: begin
                if (op_req && erase_or_write) begin
                    if (!op_aligned) begin
                        next_q.op_fault = 1'b1;
                    end else if (q.mode == `FPG_MODE_CHIP) begin
                        if (q.lock != {`FPG_GROUPS{1'b1}}) begin
                            set_ev[`FPG_EV_LOCK] = 1'b1;
                        end else if (exec_in_flash) begin
                            set_ev[`FPG_EV_PC] = 1'b1;
                        end else begin
                            next_q.go = 1'b1;
                            next_q.kind = `FPG_MODE_CHIP;
                            next_q.page = 6'h0;
                            next_q.state = fpg_pkg::st_op;
                        end
                    end else if (!group_open) begin
                        set_ev[`FPG_EV_LOCK] = 1'b1;
                    end else if (on_pc_page) begin
                        set_ev[`FPG_EV_PC] = 1'b1;
                    end else begin
                        next_q.go = 1'b1;
                        next_q.kind = q.mode;
                        next_q.page = tgt_page;
                        next_q.stall = exec_in_flash;
                        next_q.state = fpg_pkg::st_op;
                    end
                end else if (lvl_req) begin
                    if (q.cfg_count >= `FPG_CFG_MAX) begin
                        next_q.refused = 1'b1;
                    end else if (lower_ok) begin
                        next_q.go = 1'b1;
                        next_q.kind = `FPG_MODE_CHIP;
                        next_q.page = 6'h0;
                        next_q.state = fpg_pkg::st_wipe;
                    end else if (raise_ok) begin
                        next_q.level = lvl_value;
                        next_q.cfg_count = q.cfg_count + 6'h1;
                        next_q.done = 1'b1;
                    end else begin
                        next_q.refused = 1'b1;
                    end
                end
            end
            fpg_pkg::st_op: begin
                if (array_done) begin
                    set_ev[`FPG_EV_PROG] = array_prog_err;
                    next_q.stall = 1'b0;
                    next_q.state = fpg_pkg::st_idle;
                end
            end
            fpg_pkg::st_wipe: begin
                if (array_done) begin
                    next_q.level = `FPG_LVL_0;
                    next_q.cfg_count = q.cfg_count + 6'h1;
                    next_q.done = 1'b1;
                    next_q.state = fpg_pkg::st_idle;
                end
            end
            default: next_q.state = fpg_pkg::st_idle;
        endcase

        next_q.flags = (q.flags & ~clr_ev) | set_ev;
        next_q.lowpower = q.standby && lowest_power_state;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
            q.state <= fpg_pkg::st_idle;
            q.lock <= `FPG_LOCK_RST;
            q.standby <= `FPG_STANDBY_RST;
        end else begin
            q <= next_q;
        end
    end

    fpg_read_gate u_read_gate (
        .clock(clock),
        .rst_n(rst_n),
        .level(q.level),
        .rd_req(rd_req),
        .rd_src(rd_src),
        .rd_size(rd_size),
        .rd_low(rd_low),
        .rd_word(rd_word),
        .rd_data(rd_data),
        .rd_valid(rd_valid),
        .rd_denied(rd_denied),
        .rd_fault(rd_fault)
    );

    assign reg_rdata = q.rdata;
    assign fetch_stall = q.stall && q.state == fpg_pkg::st_op;
    assign op_go = q.go;
    assign op_kind = q.kind;
    assign op_page = q.page;
    assign lvl_done = q.done;
    assign lvl_refused = q.refused;
    assign flash_lowpower = q.lowpower;
    assign severe_fault_exception = q.op_fault | rd_fault;
    assign irq = |(q.flags & q.enables);

    chk_lock_refuse: assert property (@(posedge clock) disable iff (!rst_n)
        q.state == fpg_pkg::st_idle && op_req && erase_or_write && op_aligned
        && q.mode != `FPG_MODE_CHIP && !group_open |=> !op_go && q.flags[`FPG_EV_LOCK])
        else $error("locked page operation was not refused");
    chk_pc_page: assert property (@(posedge clock) disable iff (!rst_n)
        q.state == fpg_pkg::st_idle && op_req && erase_or_write && op_aligned
        && group_open && on_pc_page && q.mode != `FPG_MODE_CHIP
        |=> !op_go && q.flags[`FPG_EV_PC])
        else $error("executing page operation was not refused");
    chk_bad_key: assert property (@(posedge clock) disable iff (!rst_n)
        reg_write && reg_addr == `FPG_OFS_LOCK && !key_ok |=> $stable(q.lock))
        else $error("lock register changed without key");
    chk_irq_follow: assert property (@(posedge clock) disable iff (!rst_n)
        set_ev[`FPG_EV_LOCK] && q.enables[`FPG_EV_LOCK]
        && !(reg_write && reg_addr == `FPG_OFS_ENA) |=> irq)
        else $error("interrupt request wrong");
    chk_flag_clear: assert property (@(posedge clock) disable iff (!rst_n)
        reg_write && reg_addr == `FPG_OFS_CLR && !reg_wdata[`FPG_EV_PC] && !set_ev[`FPG_EV_PC]
        |=> !q.flags[`FPG_EV_PC])
        else $error("flag not cleared by zero write");
    chk_level_three: assert property (@(posedge clock) disable iff (!rst_n)
        q.level == `FPG_LVL_3 |=> q.level == `FPG_LVL_3)
        else $error("level three was lowered");
    chk_cfg_limit: assert property (@(posedge clock) disable iff (!rst_n)
        q.cfg_count >= `FPG_CFG_MAX |=> $stable(q.level) && $stable(q.cfg_count))
        else $error("level configured beyond limit");
    chk_busy_stall: assert property (@(posedge clock) disable iff (!rst_n)
        q.state == fpg_pkg::st_idle && op_req && erase_or_write && op_aligned && group_open
        && !on_pc_page && exec_in_flash && q.mode != `FPG_MODE_CHIP |=> op_go && fetch_stall)
        else $error("fetch not stalled during operation");
    chk_wipe_level: assert property (@(posedge clock) disable iff (!rst_n)
        q.state == fpg_pkg::st_wipe && array_done |=> q.level == `FPG_LVL_0 && lvl_done)
        else $error("level not lowered after wipe");
    chk_low_power: assert property (@(posedge clock) disable iff (!rst_n)
        q.standby && lowest_power_state |=> flash_lowpower)
        else $error("flash did not enter low power");
endmodule : fpg_guard

// ===== hdl/fpg_read_gate.sv
/*
 Read path of the flash page guard: protection gate, alignment, byte lanes.
 Assumes the array word arrives in the same cycle as the read request.
*/
`include "fpg_map.svh"
module fpg_read_gate (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // protection level
    input wire logic [1:0] level,
    // read request
    input wire logic rd_req,
    input wire fpg_pkg::fpg_src_e rd_src,
    input wire logic [1:0] rd_size,
    input wire logic [1:0] rd_low,
    input wire logic [31:0] rd_word,
    // read answer
    output logic [31:0] rd_data,
    output logic rd_valid,
    output logic rd_denied,
    output logic rd_fault
);
    typedef struct packed {
        logic [31:0] data;
        logic valid;
        logic denied;
        logic fault;
    } fpg_rg_s;

    fpg_rg_s q;
    fpg_rg_s next_q;
    logic aligned;
    logic allowed;
    logic [31:0] shifted;

    always_comb begin
        aligned = fpg_pkg::fpg_aligned(rd_size, rd_low);
        allowed = (rd_src == fpg_pkg::src_cpu) || (level == `FPG_LVL_0);
        shifted = rd_word >> {rd_low, 3'h0};
        next_q = '0;
        if (rd_req && !aligned) begin
            next_q.fault = 1'b1;
        end else if (rd_req && !allowed) begin
            next_q.denied = 1'b1;
        end else if (rd_req) begin
            next_q.valid = 1'b1;
            case (rd_size)
                `FPG_SIZE_8: next_q.data = {24'h0, shifted[7:0]};
                `FPG_SIZE_16: next_q.data = {16'h0, shifted[15:0]};
                default: next_q.data = shifted;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign rd_data = q.data;
    assign rd_valid = q.valid;
    assign rd_denied = q.denied;
    assign rd_fault = q.fault;

    chk_gate_level: assert property (@(posedge clock) disable iff (!rst_n)
        rd_req && rd_src != fpg_pkg::src_cpu && level != `FPG_LVL_0 |=> !rd_valid)
        else $error("protected read was delivered");
endmodule : fpg_read_gate

// ===== test/fpg_array_model.sv
/*
 Behavioural flash array standing behind the page guard.
 Assumes op_go is a one-cycle pulse and the guard samples array_prog_err only with array_done.
*/
module fpg_array_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bench controls
    input wire logic [7:0] delay,
    input wire logic fail_next,
    // array handshake
    input wire logic op_go,
    output logic array_done,
    output logic array_prog_err
);
    logic [7:0] left;
    logic junk;

    always_ff @(posedge clock) begin
        junk <= ~junk;
        array_done <= 1'b0;
        if (!rst_n) begin
            left <= 8'h00;
            junk <= 1'b0;
        end else if (op_go) begin
            left <= delay;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
            array_done <= (left == 8'h01);
        end
    end

    // error line carries meaning only beside done, otherwise it wanders
    assign array_prog_err = array_done ? fail_next : junk;
endmodule : fpg_array_model

// ===== test/fpg_guard_tb_top.sv
/*
 Self-checking bench of the flash page guard with a behavioural array.
 Assumes fpg_map.svh on the include path and fpg_pkg compiled first.
*/
`include "fpg_map.svh"
`define chk(what, exp, got) \
    begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module fpg_guard_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        fpg_pkg::fpg_src_e src;
        logic [1:0] size;
        logic [1:0] low;
        logic fault;
        logic [31:0] data;
    } fpg_row_s;
    logic clock, rst_n, reg_write, reg_read, op_req, exec_in_flash, op_go, array_done;
    logic array_prog_err, rd_req, rd_valid, rd_denied, lvl_req, lvl_done, lvl_refused;
    logic lowest_power_state, flash_lowpower, severe_fault_exception, irq, fetch_stall;
    logic fail_next, ok;
    logic [7:0] reg_addr, delay;
    logic [31:0] reg_wdata, reg_rdata, rd_word, rd_data;
    logic [14:0] op_addr, pc_addr;
    logic [1:0] op_size, op_kind, rd_size, rd_low, lvl_value, seen_kind;
    logic [5:0] op_page;
    fpg_pkg::fpg_src_e rd_src, lvl_src;
    int mismatches, comparisons;
    fpg_row_s rows [7] = '{
        '{fpg_pkg::src_cpu, `FPG_SIZE_8, 2'h3, 1'b0, 32'h0000_0044},
        '{fpg_pkg::src_cpu, `FPG_SIZE_16, 2'h2, 1'b0, 32'h0000_4433},
        '{fpg_pkg::src_debug, `FPG_SIZE_32, 2'h0, 1'b0, 32'h4433_2211},
        '{fpg_pkg::src_boot, `FPG_SIZE_16, 2'h0, 1'b0, 32'h0000_2211},
        '{fpg_pkg::src_debug, `FPG_SIZE_8, 2'h1, 1'b0, 32'h0000_0022},
        '{fpg_pkg::src_cpu, `FPG_SIZE_16, 2'h1, 1'b1, 32'h0000_0000},
        '{fpg_pkg::src_boot, `FPG_SIZE_32, 2'h2, 1'b1, 32'h0000_0000}};

    fpg_guard u_fpg_guard (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .op_req(op_req), .op_addr(op_addr), .op_size(op_size),
        .exec_in_flash(exec_in_flash), .pc_addr(pc_addr), .fetch_stall(fetch_stall),
        .op_go(op_go), .op_kind(op_kind), .op_page(op_page), .array_done(array_done),
        .array_prog_err(array_prog_err), .rd_req(rd_req), .rd_src(rd_src),
        .rd_size(rd_size), .rd_low(rd_low), .rd_word(rd_word), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_denied(rd_denied), .lvl_req(lvl_req),
        .lvl_value(lvl_value), .lvl_src(lvl_src), .lvl_done(lvl_done),
        .lvl_refused(lvl_refused), .lowest_power_state(lowest_power_state),
        .flash_lowpower(flash_lowpower), .severe_fault_exception(severe_fault_exception),
        .irq(irq));
    fpg_array_model u_fpg_array_model (.clock(clock), .rst_n(rst_n), .delay(delay),
        .fail_next(fail_next), .op_go(op_go), .array_done(array_done),
        .array_prog_err(array_prog_err));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock) begin
        if (op_go === 1'b1) seen_kind <= op_kind;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] v;
        rd(a, v);
        `chk(what, e, v)
    endtask : rchk

    task automatic op(input logic [14:0] a, input logic [1:0] s);
        @(posedge clock);
        op_req <= 1'b1;
        op_addr <= a;
        op_size <= s;
        @(posedge clock);
        op_req <= 1'b0;
        #1;
    endtask : op

    task automatic rdp(input fpg_pkg::fpg_src_e s, input logic [1:0] z, input logic [1:0] l);
        @(posedge clock);
        rd_req <= 1'b1;
        rd_src <= s;
        rd_size <= z;
        rd_low <= l;
        @(posedge clock);
        rd_req <= 1'b0;
        #1;
    endtask : rdp

    task automatic poll_idle;
        logic [31:0] v;
        int n;
        n = 0;
        v = 32'h0000_0020;
        while (v[5] !== 1'b0 && n < 100) begin
            rd(`FPG_OFS_CTRL, v);
            n++;
        end
        `chk("busy after op", 1'b0, v[5])
    endtask : poll_idle

    task automatic lvl(input logic [1:0] v, input fpg_pkg::fpg_src_e s, output logic done);
        int n;
        @(posedge clock);
        lvl_req <= 1'b1;
        lvl_value <= v;
        lvl_src <= s;
        @(posedge clock);
        lvl_req <= 1'b0;
        n = 0;
        #1;
        while (lvl_done !== 1'b1 && lvl_refused !== 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        done = lvl_done;
        `chk("level answer", 1'b1, lvl_done ^ lvl_refused)
    endtask : lvl

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        close_out();
    end

    initial begin
        {rst_n, reg_write, reg_read, op_req, exec_in_flash, rd_req, lvl_req} = '0;
        {lowest_power_state, fail_next, reg_addr, reg_wdata, op_addr, pc_addr} = '0;
        {op_size, rd_size, rd_low, lvl_value} = '0;
        rd_src = fpg_pkg::src_cpu;
        lvl_src = fpg_pkg::src_cpu;
        rd_word = 32'h4433_2211;
        delay = 8'h05;
        mismatches = 0;
        comparisons = 0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rchk(`FPG_OFS_CTRL, 32'h0000_0010, "control reset");
        rchk(`FPG_OFS_LOCK, 32'h0000_0000, "lock reset");
        foreach (rows[i]) begin
            rdp(rows[i].src, rows[i].size, rows[i].low);
            `chk("read fault", rows[i].fault, severe_fault_exception)
            `chk("read valid", !rows[i].fault, rd_valid)
            if (!rows[i].fault) `chk("read data", rows[i].data, rd_data)
        end
        wr(`FPG_OFS_LOCK, 32'h1234_03ff);
        rchk(`FPG_OFS_LOCK, 32'h0000_0000, "lock bad key");
        wr(`FPG_OFS_LOCK, 32'h5a5a_0002);
        rchk(`FPG_OFS_LOCK, 32'h0000_0002, "lock good key");
        wr(`FPG_OFS_CTRL, 32'h5a5a_00d2);
        rchk(`FPG_OFS_CTRL, 32'h0000_0012, "control level ro");
        wr(`FPG_OFS_CTRL, 32'h0000_0001);
        rchk(`FPG_OFS_CTRL, 32'h0000_0012, "control bad key");
        wr(`FPG_OFS_ENA, 32'h0000_0013);
        op(15'h0000, `FPG_SIZE_32);
        `chk("go on closed page", 1'b0, op_go)
        rchk(`FPG_OFS_FLAG, 32'h0000_0002, "lock flag");
        `chk("irq lock", 1'b1, irq)
        wr(`FPG_OFS_CLR, 32'hffff_fffd);
        rchk(`FPG_OFS_FLAG, 32'h0000_0000, "lock flag clear");
        `chk("irq cleared", 1'b0, irq)
        op(15'h0e00, `FPG_SIZE_32);
        `chk("go open page", 1'b1, op_go)
        `chk("page of op", 6'h07, op_page)
        `chk("kind page erase", `FPG_MODE_PAGE, op_kind)
        `chk("no stall from ram", 1'b0, fetch_stall)
        rchk(`FPG_OFS_CTRL, 32'h0000_0032, "busy during op");
        poll_idle();
        exec_in_flash <= 1'b1;
        pc_addr <= 15'h0810;
        op(15'h0800, `FPG_SIZE_8);
        `chk("go on pc page", 1'b0, op_go)
        rchk(`FPG_OFS_FLAG, 32'h0000_0001, "pc flag");
        wr(`FPG_OFS_CLR, 32'hffff_fffe);
        op(15'h0a00, `FPG_SIZE_8);
        `chk("go beside pc page", 1'b1, op_go)
        `chk("stall in flash", 1'b1, fetch_stall)
        poll_idle();
        `chk("stall released", 1'b0, fetch_stall)
        exec_in_flash <= 1'b0;
        wr(`FPG_OFS_LOCK, 32'h5a5a_0202);
        op(15'h4e00, `FPG_SIZE_32);
        `chk("last page", 6'h27, op_page)
        poll_idle();
        op(15'h5000, `FPG_SIZE_32);
        `chk("go past array", 1'b0, op_go)
        rchk(`FPG_OFS_FLAG, 32'h0000_0002, "flag past array");
        wr(`FPG_OFS_CLR, 32'hffff_fffd);
        op(15'h0e01, `FPG_SIZE_16);
        `chk("op misaligned", 1'b1, severe_fault_exception)
        `chk("no go misaligned", 1'b0, op_go)
        wr(`FPG_OFS_CTRL, 32'h5a5a_0011);
        fail_next <= 1'b1;
        op(15'h0e00, `FPG_SIZE_8);
        `chk("kind program", `FPG_MODE_PROG, op_kind)
        poll_idle();
        fail_next <= 1'b0;
        rchk(`FPG_OFS_FLAG, 32'h0000_0010, "program error flag");
        wr(`FPG_OFS_CTRL, 32'h5a5a_0013);
        op(15'h0000, `FPG_SIZE_32);
        `chk("chip erase closed", 1'b0, op_go)
        rchk(`FPG_OFS_FLAG, 32'h0000_0012, "chip lock flag");
        wr(`FPG_OFS_LOCK, 32'h5a5a_03ff);
        op(15'h0000, `FPG_SIZE_32);
        `chk("kind chip erase", `FPG_MODE_CHIP, op_kind)
        poll_idle();
        wr(`FPG_OFS_CLR, 32'hffff_ffed);
        wr(`FPG_OFS_CTRL, 32'h5a5a_0010);
        lowest_power_state <= 1'b1;
        repeat (3) @(posedge clock);
        #1 `chk("lowpower on", 1'b1, flash_lowpower)
        wr(`FPG_OFS_CTRL, 32'h5a5a_0000);
        repeat (3) @(posedge clock);
        #1 `chk("lowpower off", 1'b0, flash_lowpower)
        lowest_power_state <= 1'b0;
        lvl(`FPG_LVL_1, fpg_pkg::src_boot, ok);
        rdp(fpg_pkg::src_debug, `FPG_SIZE_32, 2'h0);
        `chk("debug read level 1", 1'b1, rd_denied)
        rdp(fpg_pkg::src_boot, `FPG_SIZE_8, 2'h0);
        `chk("boot read level 1", 1'b1, rd_denied)
        rdp(fpg_pkg::src_cpu, `FPG_SIZE_32, 2'h0);
        `chk("cpu read level 1", 1'b1, rd_valid)
        lvl(`FPG_LVL_0, fpg_pkg::src_debug, ok);
        `chk("debug lower level 1", 1'b1, ok)
        `chk("wipe kind", `FPG_MODE_CHIP, seen_kind)
        rchk(`FPG_OFS_CTRL, 32'h0000_0000, "level after wipe");
        lvl(`FPG_LVL_2, fpg_pkg::src_boot, ok);
        lvl(`FPG_LVL_0, fpg_pkg::src_debug, ok);
        `chk("debug lower level 2", 1'b0, ok)
        lvl(`FPG_LVL_0, fpg_pkg::src_boot, ok);
        `chk("boot lower level 2", 1'b1, ok)
        lvl(`FPG_LVL_3, fpg_pkg::src_boot, ok);
        lvl(`FPG_LVL_0, fpg_pkg::src_boot, ok);
        `chk("boot lower level 3", 1'b0, ok)
        lvl(`FPG_LVL_0, fpg_pkg::src_debug, ok);
        `chk("debug lower level 3", 1'b0, ok)
        rchk(`FPG_OFS_CTRL, 32'h0000_00c0, "level 3 kept");
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rchk(`FPG_OFS_CTRL, 32'h0000_0010, "control second reset");
        for (int i = 0; i < 24; i++) begin
            lvl(`FPG_LVL_1, fpg_pkg::src_boot, ok);
            lvl(`FPG_LVL_0, fpg_pkg::src_debug, ok);
        end
        `chk("last allowed change", 1'b1, ok)
        lvl(`FPG_LVL_1, fpg_pkg::src_boot, ok);
        `chk("change past limit", 1'b0, ok)
        close_out();
    end
endmodule : fpg_guard_tb_top
